// ==== inc/pdsc_pkg.sv ====
package pdsc_pkg;

  // Bus geometry
  localparam int AXI_AW = 12;              // Byte address width
  localparam int AXI_DW = 32;              // Data width
  localparam int REG_W  = 16;              // Width of each config register

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PLL_CTRL = 8'h18;  // Multiplier enable
  localparam logic [7:0] IDX_DIV      = 8'h19;  // Feedback/reference div
  localparam logic [7:0] IDX_PD       = 8'h1a;  // Coarse tune, power-down
  localparam logic [7:0] IDX_REFSEL   = 8'h1b;  // Reference select
  localparam logic [7:0] IDX_STATUS   = 8'h1c;  // Decoded divider status

  // Reset values
  localparam logic [15:0] RST_PLL_CTRL = 16'h0000;
  localparam logic [15:0] RST_DIV      = 16'h0440;
  localparam logic [15:0] RST_PD       = 16'h0020;
  localparam logic [15:0] RST_REFSEL   = 16'h0000;

  // Writable bits; reserved bits store nothing and read as zero
  localparam logic [15:0] MASK_PLL_CTRL = 16'h0400;
  localparam logic [15:0] MASK_DIV      = 16'hfffc;
  localparam logic [15:0] MASK_PD       = 16'hfcff;
  localparam logic [15:0] MASK_REFSEL   = 16'hffff;

  // Field positions
  localparam int PLL_ENA_BIT   = 10;
  localparam int FB_MODE_BIT   = 15;       // Doubling mode of feedback div
  localparam int FB_LO_HI      = 14;       // Lower seven bits of feedback
  localparam int FB_LO_LO      = 8;
  localparam int REF_HI        = 7;
  localparam int REF_LO        = 4;
  localparam int BIAS_HI       = 3;
  localparam int BIAS_LO       = 2;
  localparam int COARSE_HI     = 15;
  localparam int COARSE_LO     = 10;
  localparam int BIAS_SLP_BIT  = 7;
  localparam int TSENSE_BIT    = 6;
  localparam int PLL_SLP_BIT   = 5;
  localparam int CLKRX_BIT     = 4;
  localparam int CHAN_A_BIT    = 3;
  localparam int CHAN_B_BIT    = 2;
  localparam int CHAN_C_BIT    = 1;
  localparam int CHAN_D_BIT    = 0;

  // Lowest legal seven-bit feedback code in either mode
  localparam logic [6:0] FB_MIN_CODE = 7'h04;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Settings handed to the analog clock multiplier
  typedef struct packed {
    logic       enable;                    // Multiplier used, not bypassed
    logic       active;                    // Enabled and awake
    logic [7:0] fb_div;                    // Feedback divide value
    logic       fb_div_bad;                // Feedback code is illegal
    logic [4:0] ref_div;                   // Reference divide ratio 1..16
    logic [1:0] bias_tune;                 // VCO bias tuning
    logic [5:0] coarse;                    // VCO coarse tuning code
  } pdsc_pll_cfg_t;

  // Power-down levels
  typedef struct packed {
    logic bias_sleep;
    logic tsense_off;
    logic pll_sleep;
    logic clk_rx_sleep;
    logic output_strobe_sync_sleep;
    logic channel_a_powerdown;
    logic channel_b_powerdown;
    logic channel_c_powerdown;
    logic channel_d_powerdown;
  } pdsc_pwr_t;

endpackage : pdsc_pkg

// ==== hw/pdsc_regs.sv ====
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Top bit clear: divide by low seven
// - Top bit set: divide by twice low
// - Reference ratio is field plus one
// - Divider register resets to 0x0440
// - Coarse tuning bits 15:10 reset zero
// - Bit 7 sleeps bias amplifier
// - Bit 6 switches temperature sensor off
// - Bit 5 sleeps multiplier, reset one
// - Bit 4 sleeps clock and strobe receivers
// - Bits 3..0 sleep channels A..D
// - Power-down register resets to 0x0020
// - Enable bit selects multiplier or bypass
module pdsc_regs
  import pdsc_pkg::*;
(
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // Write address channel
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // Write data channel
  input  wire logic [AXI_DW-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // Write response channel
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // Read address channel
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // Read data channel
  output logic [AXI_DW-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Static levels to the analog blocks
  output pdsc_pll_cfg_t            pll_cfg,
  output pdsc_pwr_t                pwr
);

  // Byte address of a register index
  // Registers sit one per aligned word, so the index is shifted by two
  // and the low address bits must be zero for a hit
  function automatic logic [AXI_AW-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'h0, idx, 2'h0};
  endfunction : byte_addr

  // True when the address hits a register word
  // Shared by the write answer and the read decode
  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    is_mapped = (a == byte_addr(IDX_PLL_CTRL)) ||
                (a == byte_addr(IDX_DIV))      ||
                (a == byte_addr(IDX_PD))       ||
                (a == byte_addr(IDX_REFSEL))   ||
                (a == byte_addr(IDX_STATUS));
  endfunction : is_mapped

  // Merge a write into a register through strobes and writable mask
  // Only the two low strobes matter; the upper half of the bus word has
  // no storage behind it, and reserved bits never keep a one, so reads
  // of them stay zero whatever software wrote
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                             input logic [AXI_DW-1:0] d,
                                             input logic [3:0] strb,
                                             input logic [REG_W-1:0] mask);
    logic [REG_W-1:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = d[7:0];
    end
    if (strb[1]) begin
      m[15:8] = d[15:8];
    end
    merge = m & mask;
  endfunction : merge

  // Feedback divide value from the eight-bit field
  // Illegal low codes are passed through as they are; the flag beside
  // the value tells the multiplier they must not be used
  // Codes below four in either mode raise that flag
  function automatic logic [7:0] fb_value(input logic [REG_W-1:0] r);
    if (r[FB_MODE_BIT]) begin
      fb_value = {r[FB_LO_HI:FB_LO_LO], 1'b0};
    end else begin
      fb_value = {1'b0, r[FB_LO_HI:FB_LO_LO]};
    end
  endfunction : fb_value

  // Bus state machines
  // Each direction has its own two-state machine, so a read never waits
  // on a write and the other way round
  typedef enum logic {PDSC_WR_IDLE, PDSC_WR_RESP} pdsc_wr_st_t;
  typedef enum logic {PDSC_RD_IDLE, PDSC_RD_DATA} pdsc_rd_st_t;

  // Bus-side flops
  pdsc_wr_st_t        wr_st_r;            // Write response pending
  pdsc_rd_st_t        rd_st_r;            // Read data pending
  logic               awready_r;          // Address slot free
  logic               wready_r;           // Data slot free
  logic               aw_got_r;           // Address held
  logic               w_got_r;            // Data held
  logic [AXI_AW-1:0]  aw_addr_r;          // Held write address
  logic [AXI_DW-1:0]  w_data_r;           // Held write data
  logic [3:0]         w_strb_r;           // Held byte strobes
  logic [1:0]         bresp_r;            // Write response code
  logic               arready_r;          // Read address slot free
  logic [AXI_DW-1:0]  rdata_r;            // Read data
  logic [1:0]         rresp_r;            // Read response code
  // Configuration storage
  logic [REG_W-1:0]   pll_ctrl_r;         // Multiplier enable register
  logic [REG_W-1:0]   div_r;              // Divider register
  logic [REG_W-1:0]   pd_r;               // Coarse tune and power-down
  logic [REG_W-1:0]   refsel_r;           // Reference select register
  // Output flops
  pdsc_pll_cfg_t      pll_cfg_r;          // Multiplier output flops
  pdsc_pwr_t          pwr_r;              // Power-down output flops
  // Handshake and decode terms
  logic               do_write;           // Both halves of a write held
  logic               aw_hs;              // Address handshake
  logic               w_hs;               // Data handshake
  logic               ar_hs;              // Read address handshake
  logic [REG_W-1:0]   status_w;           // Status word from outputs

  // A beat moves only while its slot is open
  assign aw_hs    = s_axi_awvalid && awready_r;
  assign w_hs     = s_axi_wvalid && wready_r;
  assign ar_hs    = s_axi_arvalid && arready_r;
  assign do_write = aw_got_r && w_got_r && (wr_st_r == PDSC_WR_IDLE);
  // Status word mirrors the decoded outputs, so it reads what the
  // analog side really sees
  assign status_w = {1'b0, pll_cfg_r.active, pll_cfg_r.fb_div_bad,
                     pll_cfg_r.ref_div, pll_cfg_r.fb_div};

  // Write address slot; taken in either order with the data
  // The slot stays shut from the take until the response is accepted,
  // which keeps a second write from overtaking the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_got_r  <= 1'b0;
      aw_addr_r <= '0;
    end else if (aw_hs) begin
      awready_r <= 1'b0;
      aw_got_r  <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got_r  <= 1'b0;
    end else if (!aw_got_r && wr_st_r == PDSC_WR_IDLE) begin
      awready_r <= 1'b1;
    end
  end

  // Write data slot
  // Mirrors the address slot, so either half may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_got_r  <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (w_hs) begin
      wready_r <= 1'b0;
      w_got_r  <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_got_r  <= 1'b0;
    end else if (!w_got_r && wr_st_r == PDSC_WR_IDLE) begin
      wready_r <= 1'b1;
    end
  end

  // Write response; unmapped or read-only addresses answer SLVERR
  // The answer is decided once both halves are held; bresp stays put
  // until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_r <= PDSC_WR_IDLE;
      bresp_r <= RESP_OKAY;
    end else begin
      case (wr_st_r)
        PDSC_WR_IDLE: begin
          if (do_write) begin
            wr_st_r <= PDSC_WR_RESP;
            if (is_mapped(aw_addr_r) &&
                aw_addr_r != byte_addr(IDX_STATUS)) begin
              bresp_r <= RESP_OKAY;
            end else begin
              bresp_r <= RESP_SLVERR;
            end
          end
        end
        PDSC_WR_RESP: begin
          if (s_axi_bready) begin
            wr_st_r <= PDSC_WR_IDLE;
          end
        end
        default: begin
          // Unused encoding falls back to idle
          wr_st_r <= PDSC_WR_IDLE;
        end
      endcase
    end
  end

  // Configuration registers; reserved bits masked to zero
  // A write to any other address, or to the status word, leaves all
  // four untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_ctrl_r <= RST_PLL_CTRL;
      div_r      <= RST_DIV;
      pd_r       <= RST_PD;
      refsel_r   <= RST_REFSEL;
    end else if (do_write) begin
      if (aw_addr_r == byte_addr(IDX_PLL_CTRL)) begin
        pll_ctrl_r <= merge(pll_ctrl_r, w_data_r, w_strb_r, MASK_PLL_CTRL);
      end
      if (aw_addr_r == byte_addr(IDX_DIV)) begin
        div_r <= merge(div_r, w_data_r, w_strb_r, MASK_DIV);
      end
      if (aw_addr_r == byte_addr(IDX_PD)) begin
        pd_r <= merge(pd_r, w_data_r, w_strb_r, MASK_PD);
      end
      if (aw_addr_r == byte_addr(IDX_REFSEL)) begin
        refsel_r <= merge(refsel_r, w_data_r, w_strb_r, MASK_REFSEL);
      end
    end
  end

  // Read channel; one read in flight, data one cycle after address
  // The address is decoded at the take, so rdata is a snapshot that
  // holds while rvalid waits for rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_r   <= PDSC_RD_IDLE;
      arready_r <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      case (rd_st_r)
        PDSC_RD_IDLE: begin
          if (ar_hs) begin
            rd_st_r   <= PDSC_RD_DATA;
            arready_r <= 1'b0;
            rresp_r   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            // Unmapped addresses read as zero
            rdata_r   <= '0;
            if (s_axi_araddr == byte_addr(IDX_PLL_CTRL)) begin
              rdata_r[REG_W-1:0] <= pll_ctrl_r;
            end
            if (s_axi_araddr == byte_addr(IDX_DIV)) begin
              rdata_r[REG_W-1:0] <= div_r;
            end
            if (s_axi_araddr == byte_addr(IDX_PD)) begin
              rdata_r[REG_W-1:0] <= pd_r;
            end
            if (s_axi_araddr == byte_addr(IDX_REFSEL)) begin
              rdata_r[REG_W-1:0] <= refsel_r;
            end
            if (s_axi_araddr == byte_addr(IDX_STATUS)) begin
              rdata_r[REG_W-1:0] <= status_w;
            end
          end else begin
            arready_r <= 1'b1;
          end
        end
        PDSC_RD_DATA: begin
          if (s_axi_rready) begin
            rd_st_r <= PDSC_RD_IDLE;
          end
        end
        default: begin
          // Unused encoding falls back to idle
          rd_st_r <= PDSC_RD_IDLE;
        end
      endcase
    end
  end

  // Multiplier settings, registered one cycle behind the fields
  // Decoded values are driven even while the multiplier is bypassed;
  // active tells the analog side when they are in use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_cfg_r <= '0;
    end else begin
      pll_cfg_r.enable     <= pll_ctrl_r[PLL_ENA_BIT];
      pll_cfg_r.active     <= pll_ctrl_r[PLL_ENA_BIT] &&
                              !pd_r[PLL_SLP_BIT];
      pll_cfg_r.fb_div     <= fb_value(div_r);
      pll_cfg_r.fb_div_bad <= div_r[FB_LO_HI:FB_LO_LO] < FB_MIN_CODE;
      pll_cfg_r.ref_div    <= {1'b0, div_r[REF_HI:REF_LO]} + 5'h01;
      // Held at whatever software wrote; 01b is its job after reset
      pll_cfg_r.bias_tune  <= div_r[BIAS_HI:BIAS_LO];
      pll_cfg_r.coarse     <= pd_r[COARSE_HI:COARSE_LO];
    end
  end

  // Power-down levels
  // Each sleep level is a plain copy of its bit; reset leaves only the
  // multiplier asleep, matching the register default
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_r           <= '0;
      pwr_r.pll_sleep <= RST_PD[PLL_SLP_BIT];
    end else begin
      pwr_r.bias_sleep   <= pd_r[BIAS_SLP_BIT];
      pwr_r.tsense_off   <= pd_r[TSENSE_BIT];
      pwr_r.pll_sleep    <= pd_r[PLL_SLP_BIT];
      // Both receivers share one control
      pwr_r.clk_rx_sleep             <= pd_r[CLKRX_BIT];
      pwr_r.output_strobe_sync_sleep <= pd_r[CLKRX_BIT];
      pwr_r.channel_a_powerdown <= pd_r[CHAN_A_BIT];
      pwr_r.channel_b_powerdown <= pd_r[CHAN_B_BIT];
      pwr_r.channel_c_powerdown <= pd_r[CHAN_C_BIT];
      pwr_r.channel_d_powerdown <= pd_r[CHAN_D_BIT];
    end
  end

  // Port drive, all from flops
  // Valid flags are the one-bit state flops themselves
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = (wr_st_r == PDSC_WR_RESP);
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = (rd_st_r == PDSC_RD_DATA);
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign pll_cfg       = pll_cfg_r;
  assign pwr           = pwr_r;

endmodule : pdsc_regs

// ==== tb/pdsc_regs_properties.sv ====
`timescale 1ns/1ps
module pdsc_regs_properties
  import pdsc_pkg::*;
(
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Bus handshakes
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [AXI_DW-1:0]   s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  // Analog levels
  input wire pdsc_pll_cfg_t       pll_cfg,
  input wire pdsc_pwr_t           pwr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read answers one cycle after the address is taken
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  // Write answers two edges after both halves are taken
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer off");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  // Decoded divider values stay inside their legal spans; active and receiver levels agree
  a_fb_bad_range: assert property ($past(aresetn) |->
    (pll_cfg.fb_div_bad ? pll_cfg.fb_div < 8'h08 : pll_cfg.fb_div >= 8'h04))
    else $error("feedback flag wrong");
  a_ref_range: assert property ($past(aresetn) |->
    pll_cfg.ref_div inside {[5'h01:5'h10]}) else $error("ref ratio out");
  a_pll_active: assert property ($past(aresetn) |-> pll_cfg.active ==
    (pll_cfg.enable && !pwr.pll_sleep)) else $error("active wrong");
  a_strobe_pair: assert property (pwr.clk_rx_sleep ==
    pwr.output_strobe_sync_sleep) else $error("receivers split");
  // Reset leaves only the multiplier asleep
  a_pwr_reset: assert property (disable iff (1'b0) !aresetn |=>
    pwr == 9'h040) else $error("pwr reset wrong");
endmodule : pdsc_regs_properties

bind pdsc_regs pdsc_regs_properties u_props (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .pll_cfg       (pll_cfg),
  .pwr           (pwr)
);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h want %h", $time, g, e); end end
module tb;
  import pdsc_pkg::*;
  // Bus and level signals
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  pdsc_pll_cfg_t pll_cfg;
  pdsc_pwr_t     pwr;
  int n_mismatch = 0, comparisons = 0;
  pdsc_regs u_dut (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pll_cfg       (pll_cfg),
    .pwr           (pwr)
  );
  always #2.5 aclk = ~aclk;
  // Write one word, each channel released when taken; lag keeps bready
  // low for that many edges so the response must stand
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    output logic [1:0] r, input int lag = 0,
                    input logic [3:0] be = 4'h3);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= be;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n >= lag && !(s_axi_bvalid && s_axi_bready)) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) n_mismatch++;
  endtask : wr
  // Read one word; lag keeps rready low for that many edges
  task automatic rd(input logic [11:0] a, input int lag = 0);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n >= lag && !(s_axi_rvalid && s_axi_rready)) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) n_mismatch++;
  endtask : rd
  // Reset values of registers and levels
  task automatic t_reset();
    rd(12'h064);
    `CHK(rv, 32'h0000_0440)
    rd(12'h068);
    `CHK(rv, 32'h0000_0020)
    rd(12'h060);
    `CHK(rv, 32'h0)
    `CHK(pwr, 9'h040)
    `CHK({pll_cfg.fb_div, pll_cfg.ref_div}, 13'h0085)
    $display("t_reset done");
  endtask : t_reset
  // Both feedback modes, boundary codes, every end of the ratio
  task automatic t_fbdiv();
    logic [7:0] m [6] = '{8'h04, 8'h03, 8'h7f, 8'h84, 8'h83, 8'hff};
    logic [15:0] d;
    logic [7:0] fb;
    logic [4:0] rf;
    for (int i = 0; i < 6; i++) begin
      d = {m[i], 4'(i * 3), 2'b01, 2'b00};
      fb = m[i][7] ? {m[i][6:0], 1'b0} : {1'b0, m[i][6:0]};
      rf = 5'(i * 3) + 5'h01;
      wr(12'h064, d, rr);
      rd(12'h064);
      `CHK(rv, {16'h0000, d & 16'hfffc})
      `CHK(pll_cfg.fb_div, fb)
      `CHK(pll_cfg.fb_div_bad, m[i][6:0] < 7'h04)
      `CHK(pll_cfg.ref_div, rf)
      `CHK(pll_cfg.bias_tune, 2'b01)
      rd(12'h070);
      `CHK(rv, {17'h0, 1'b0, m[i][6:0] < 7'h04, rf, fb})
    end
    $display("t_fbdiv done");
  endtask : t_fbdiv
  // Each sleep bit alone, with coarse tuning alongside
  task automatic t_pwr();
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {6'(i * 9 + 1), 2'b00, 8'(1 << i)};
      wr(12'h068, d, rr);
      rd(12'h068);
      `CHK(rv, {16'h0000, d & 16'hfcff})
      `CHK(pwr, {d[7:4], d[4], d[3:0]})
      `CHK(pll_cfg.coarse, d[15:10])
    end
    $display("t_pwr done");
  endtask : t_pwr
  // Multiplier enable against its sleep control
  task automatic t_enable();
    wr(12'h060, 16'hffff, rr);
    rd(12'h060);
    `CHK(rv, 32'h0000_0400)
    `CHK({pll_cfg.enable, pll_cfg.active}, 2'b11)
    wr(12'h068, 16'h0020, rr);
    rd(12'h068);
    `CHK({pll_cfg.enable, pll_cfg.active}, 2'b10)
    $display("t_enable done");
  endtask : t_enable
  // Unmapped, misaligned and read-only places, then refsel with late ready and a low-byte write
  task automatic t_refuse();
    rd(12'h074);
    `CHK({rr, rv}, {RESP_SLVERR, 32'h0})
    rd(12'h062);
    `CHK(rr, RESP_SLVERR)
    wr(12'h070, 16'hffff, rr);
    `CHK(rr, RESP_SLVERR)
    wr(12'h080, 16'hffff, rr);
    `CHK(rr, RESP_SLVERR)
    wr(12'h06c, 16'ha5a5, rr, 3);
    rd(12'h06c, 3);
    `CHK({rr, rv}, {RESP_OKAY, 32'h0000_a5a5})
    wr(12'h06c, 16'h5a5a, rr, 0, 4'h1);
    rd(12'h06c);
    `CHK(rv, 32'h0000_a55a)
    $display("t_refuse done");
  endtask : t_refuse
  // Reset again in mid-run; written values must fall back
  task automatic t_rereset();
    wr(12'h068, 16'h04df, rr);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h06c);
    `CHK(rv, 32'h0)
    t_reset();
    $display("t_rereset done");
  endtask : t_rereset
  // Counts and verdict
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fbdiv();
    t_pwr();
    t_enable();
    t_refuse();
    t_rereset();
    end_of_test();
  end
  // Watchdog
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb
